// File: verilog/jtbp_top.sv
// Purpose: test access port with processor scan, break points and debug byte channel
// Assumes: tck, tms, tdi asynchronous pins, tck well below clk_sys/4
// Notes: tck is sampled, not used as a clock
// Function
// - sixteen-state controller steps on rising tck by tms, starts in reset state
// - every scan register shifts least significant bit first, in and out
// - tms 1,1,0,0 reaches instruction shift; captured pattern 0x01 shifts out
// - loaded instruction picks the data register between tdi and tdo
// - tms 1,1,0 returns to idle; instruction latched in instruction update
// - instruction exit and pause states only navigate
// - in data shift, tdi enters the selected register each rising tck
// - last data bit enters on the edge where tms leaves shift
// - data captured in capture state shifts out on tdo
// - selected register with parallel output updates in data update state
// - data exit and pause states only navigate
// - data scans may follow instruction scans without passing idle
// - some instructions act while the controller sits in idle
// - five tck periods with tms high always reach reset state
// - debug logic: processor scan chain, break point unit, processor byte channel
// - debugger drives the processor by scanning instructions into it
// - processor returns results by writing the byte channel location
// - breaks on flow change, single step, program and combined break points
// - four break points in four configurable program/data/range mixes
`timescale 1ns/1ns
`include "jtbp_defs.svh"
module jtbp_top import jtbp_pkg::*; #(
	parameter int FIFO_DEPTH = `JTBP_FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	output logic [3:0] ir_out,
	input wire logic [15:0] cpu_pc,
	input wire logic cpu_pc_vld,
	input wire logic [15:0] cpu_daddr,
	input wire logic cpu_dacc,
	input wire logic cpu_flow_chg,
	output logic [15:0] cpu_instr,
	output logic cpu_instr_stb,
	output logic dbg_break,
	input wire logic [7:0] cpu_ocd_data,
	input wire logic cpu_ocd_wr,
	output logic cpu_ocd_ready
);
	jtbp_top_s st, nx;
	logic rise, fall, tms_i, tdi_i, pop;
	logic f_vld;
	logic [7:0] f_data;
	logic [6:0] len;

	jtbp_bp_if bpif();

	function automatic logic [6:0] dr_len(input logic [3:0] op);
		logic [6:0] l;
		l = `JTBP_LEN_BYP;
		if (op == `JTBP_OP_SCAN) begin
			l = `JTBP_LEN_SCAN;
		end else if (op == `JTBP_OP_BPCFG) begin
			l = `JTBP_LEN_BPCFG;
		end else if (op == `JTBP_OP_COMM) begin
			l = `JTBP_LEN_COMM;
		end
		return l;
	endfunction

	function automatic logic [67:0] dr_shift(input logic [67:0] d, input logic b, input logic [6:0] l);
		logic [67:0] r;
		r = d >> 1;
		r[l - 7'h01] = b;
		return r;
	endfunction

	// edge detection looks only at second and third stages
	assign rise = st.tck_s[1] & ~st.tck_s[2];
	assign fall = ~st.tck_s[1] & st.tck_s[2];
	assign tms_i = st.tms_s[1];
	assign tdi_i = st.tdi_s[1];
	assign len = dr_len(st.ir);

	always_comb begin
		nx = st;
		pop = 1'b0;
		nx.instr_stb = 1'b0;
		nx.tck_s = {st.tck_s[1:0], tck};
		nx.tms_s = {st.tms_s[0], tms};
		nx.tdi_s = {st.tdi_s[0], tdi};
		nx.brk = bpif.hit;
		if (rise) begin
			nx.tap = jtbp_tap_next(st.tap, tms_i);
			nx.tms_ones = tms_i ? ((st.tms_ones == 3'h7) ? 3'h7 : st.tms_ones + 3'h1) : 3'h0;
			// entering reset state restores bypass at once, not one tck later
			if (jtbp_tap_next(st.tap, tms_i) == tap_tlr) begin
				nx.ir = `JTBP_OP_BYP;
			end
			case (st.tap)
				tap_tlr: begin
					nx.ir = `JTBP_OP_BYP;
				end
				tap_rti: begin
					// repeats the scanned instruction once per tck in idle
					if (st.ir == `JTBP_OP_EXEC) begin
						nx.instr_stb = 1'b1;
					end
				end
				tap_capir: begin
					nx.ir_sh = `JTBP_IR_CAP;
				end
				tap_shir: begin
					nx.ir_sh = {tdi_i, st.ir_sh[3:1]};
				end
				tap_capdr: begin
					if (st.ir == `JTBP_OP_SCAN) begin
						nx.dr = {52'h0_0000_0000_0000, cpu_pc};
					end else if (st.ir == `JTBP_OP_BPCFG) begin
						nx.dr = {st.bp_addr, st.step_en, st.flow_en, st.bp_mode};
					end else if (st.ir == `JTBP_OP_COMM) begin
						// bit 8 tells the debugger whether the byte is fresh; empty buffer reads zero
						nx.dr = {59'h0, f_vld, f_vld ? f_data : 8'h00};
						pop = f_vld;
					end else begin
						nx.dr = '0;
					end
				end
				tap_shdr: begin
					nx.dr = dr_shift(st.dr, tdi_i, len);
				end
				default: begin
					nx.tap = jtbp_tap_next(st.tap, tms_i);
				end
			endcase
		end
		if (fall) begin
			nx.tdo_oe = (st.tap == tap_shir) | (st.tap == tap_shdr);
			if (st.tap == tap_shir) begin
				nx.tdo = st.ir_sh[0];
			end else if (st.tap == tap_shdr) begin
				nx.tdo = st.dr[0];
			end
			if (st.tap == tap_updir) begin
				nx.ir = st.ir_sh;
			end
			if (st.tap == tap_upddr) begin
				if (st.ir == `JTBP_OP_SCAN) begin
					nx.instr = st.dr[15:0];
				end else if (st.ir == `JTBP_OP_BPCFG) begin
					nx.bp_mode = jtbp_bpm_e'(st.dr[`JTBP_BPC_MODE_LO +: 2]);
					nx.flow_en = st.dr[`JTBP_BPC_FLOW];
					nx.step_en = st.dr[`JTBP_BPC_STEP];
					nx.bp_addr = st.dr[67:`JTBP_BPC_ADDR_LO];
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st <= '0;
			st.tap <= tap_tlr;
			st.ir <= `JTBP_OP_BYP;
			st.instr <= `JTBP_INSTR_RST;
		end else begin
			st <= nx;
		end
	end

	// limitation: a full buffer stalls the processor, bytes are never dropped
	jtbp_fifo #(
		.WIDTH(`JTBP_COMM_W),
		.DEPTH(FIFO_DEPTH)
	) jtbp_fifo_i (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.in_valid(cpu_ocd_wr),
		.in_ready(cpu_ocd_ready),
		.in_data(cpu_ocd_data),
		.out_valid(f_vld),
		.out_ready(pop),
		.out_data(f_data)
	);

	assign bpif.mode = st.bp_mode;
	assign bpif.flow_en = st.flow_en;
	assign bpif.step_en = st.step_en;
	assign bpif.addr = st.bp_addr;
	assign bpif.pc = cpu_pc;
	assign bpif.pc_vld = cpu_pc_vld;
	assign bpif.daddr = cpu_daddr;
	assign bpif.d_vld = cpu_dacc;
	assign bpif.flow = cpu_flow_chg;

	jtbp_bpu jtbp_bpu_i (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.bp(bpif.bpu)
	);

	assign tdo = st.tdo;
	assign tdo_oe = st.tdo_oe;
	assign ir_out = st.ir;
	assign cpu_instr = st.instr;
	assign cpu_instr_stb = st.instr_stb;
	assign dbg_break = st.brk;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	tap_reset_a: assert property ($fell(sys_rst) |-> st.tap == tap_tlr && ir_out == `JTBP_OP_BYP && !tdo_oe)
		else $error("controller not in reset state after reset");
	five_ones_a: assert property (rise && tms_i && st.tms_ones >= 3'h4 |=> st.tap == tap_tlr)
		else $error("five tms highs did not reach reset state");
	ir_capture_a: assert property (rise && st.tap == tap_capir |=> st.ir_sh == `JTBP_IR_CAP)
		else $error("instruction capture pattern wrong");
	ir_shift_a: assert property (rise && st.tap == tap_shir |=> st.ir_sh == {$past(tdi_i), $past(st.ir_sh[3:1])})
		else $error("instruction shift not lsb first");
	ir_update_a: assert property (fall && st.tap == tap_updir |=> ir_out == $past(st.ir_sh))
		else $error("instruction not latched in update");
	ir_quiet_a: assert property (rise && st.tap inside {tap_ex1ir, tap_pir, tap_ex2ir} |=>
		$stable(st.ir_sh) && $stable(st.ir)) else $error("instruction navigation state changed data");
	dr_quiet_a: assert property (rise && st.tap inside {tap_ex1dr, tap_pdr, tap_ex2dr} |=>
		$stable(st.dr) && $stable(cpu_instr)) else $error("data navigation state changed data");
	comm_shift_a: assert property (rise && st.tap == tap_shdr && st.ir == `JTBP_OP_COMM |=>
		st.dr[8] == $past(tdi_i) && st.dr[7:0] == $past(st.dr[8:1])) else $error("data shift wrong");
	comm_cap_a: assert property (rise && st.tap == tap_capdr && st.ir == `JTBP_OP_COMM |=>
		st.dr[8:0] == $past(f_vld ? {1'b1, f_data} : 9'h000)) else $error("byte channel capture wrong");
	scan_update_a: assert property (fall && st.tap == tap_upddr && st.ir == `JTBP_OP_SCAN |=>
		cpu_instr == $past(st.dr[15:0])) else $error("scanned instruction not latched");
	idle_exec_a: assert property (rise && st.tap == tap_rti && st.ir == `JTBP_OP_EXEC |=> cpu_instr_stb)
		else $error("idle execution missing");
	tdo_edge_a: assert property ($changed(tdo) |-> $past(fall))
		else $error("tdo changed away from falling tck");

	tap_hold_a: assert property (!rise |=>
		$stable(st.tap))
		else $error("controller moved without a tck rise");
	bypass_load_a: assert property (rise && jtbp_tap_next(st.tap, tms_i) == tap_tlr |=>
		ir_out == `JTBP_OP_BYP)
		else $error("reset state did not load bypass");
	oe_on_a: assert property (fall && st.tap inside {tap_shir, tap_shdr} |=>
		tdo_oe)
		else $error("tdo not driven in shift state");
	oe_off_a: assert property (fall && !(st.tap inside {tap_shir, tap_shdr}) |=>
		!tdo_oe)
		else $error("tdo driven outside shift state");
	oe_edge_a: assert property ($changed(tdo_oe) |->
		$past(fall))
		else $error("tdo enable changed away from falling tck");
	tdo_ir_a: assert property (fall && st.tap == tap_shir |=>
		tdo == $past(st.ir_sh[0]))
		else $error("instruction bit out wrong");
	tdo_dr_a: assert property (fall && st.tap == tap_shdr |=>
		tdo == $past(st.dr[0]))
		else $error("data bit out wrong");

	scan_cap_a: assert property (rise && st.tap == tap_capdr && st.ir == `JTBP_OP_SCAN |=>
		st.dr[15:0] == $past(cpu_pc))
		else $error("processor scan capture wrong");
	bpcfg_cap_a: assert property (rise && st.tap == tap_capdr && st.ir == `JTBP_OP_BPCFG |=>
		st.dr[67:4] == $past(st.bp_addr) && st.dr[1:0] == $past(st.bp_mode))
		else $error("break point readback wrong");
	byp_cap_a: assert property (rise && st.tap == tap_capdr &&
		!(st.ir inside {`JTBP_OP_SCAN, `JTBP_OP_BPCFG, `JTBP_OP_COMM}) |=> st.dr == '0)
		else $error("bypass capture not zero");
	scan_shift_a: assert property (rise && st.tap == tap_shdr && st.ir == `JTBP_OP_SCAN |=>
		st.dr[15] == $past(tdi_i) && st.dr[14:0] == $past(st.dr[15:1]))
		else $error("processor scan shift wrong");
	bpcfg_shift_a: assert property (rise && st.tap == tap_shdr && st.ir == `JTBP_OP_BPCFG |=>
		st.dr[67] == $past(tdi_i) && st.dr[66:0] == $past(st.dr[67:1]))
		else $error("break point shift wrong");
	bpcfg_update_a: assert property (fall && st.tap == tap_upddr && st.ir == `JTBP_OP_BPCFG |=>
		st.bp_addr == $past(st.dr[67:4]) && st.step_en == $past(st.dr[`JTBP_BPC_STEP]))
		else $error("break point config not applied");

	stb_source_a: assert property (cpu_instr_stb |->
		$past(rise) && $past(st.tap) == tap_rti && $past(st.ir) == `JTBP_OP_EXEC)
		else $error("instruction strobe outside idle execution");
	stb_pulse_a: assert property (cpu_instr_stb |=>
		!cpu_instr_stb)
		else $error("instruction strobe longer than one cycle");
	idle_quiet_a: assert property (rise && st.tap == tap_rti && st.ir != `JTBP_OP_EXEC |=>
		!cpu_instr_stb)
		else $error("strobe without execute instruction");
	comm_pop_a: assert property (rise && st.tap == tap_capdr && st.ir == `JTBP_OP_COMM && f_vld |=>
		!f_vld)
		else $error("captured byte not taken from buffer");
	break_reg_a: assert property (bpif.hit |=>
		dbg_break)
		else $error("break unit hit not passed on");

	cover_irscan_c: cover property (fall && st.tap == tap_updir && st.ir_sh == `JTBP_OP_SCAN);
	cover_exec_c: cover property (cpu_instr_stb);
	cover_break_c: cover property (dbg_break);
	cover_full_c: cover property (!cpu_ocd_ready);
	cover_tlr_c: cover property (rise && st.tap == tap_selir && tms_i);
endmodule // jtbp_top

// File: verilog/jtbp_defs.svh
// Purpose: shared constants of the test access port and debug block
// Assumes: included by bare name from design files
// Notes: definitions only
`ifndef JTBP_DEFS_SVH
`define JTBP_DEFS_SVH

`define JTBP_IR_W 4
`define JTBP_IR_CAP 4'h1
`define JTBP_OP_SCAN 4'h8
`define JTBP_OP_EXEC 4'h9
`define JTBP_OP_BPCFG 4'hA
`define JTBP_OP_COMM 4'hB
`define JTBP_OP_BYP 4'hF
`define JTBP_DR_W 68
`define JTBP_LEN_SCAN 7'h10
`define JTBP_LEN_BPCFG 7'h44
`define JTBP_LEN_COMM 7'h09
`define JTBP_LEN_BYP 7'h01
`define JTBP_BPC_MODE_LO 0
`define JTBP_BPC_FLOW 2
`define JTBP_BPC_STEP 3
`define JTBP_BPC_ADDR_LO 4
`define JTBP_INSTR_RST 16'h0000
`define JTBP_FIFO_DEPTH 16
`define JTBP_COMM_W 8

`endif

// File: verilog/jtbp_pkg.sv
// Purpose: types of the test access port and debug block
// Assumes: nothing
// Notes: tap states one-hot
package jtbp_pkg;

	typedef enum logic [15:0] {
		tap_tlr = 16'h0001, tap_rti = 16'h0002, tap_seldr = 16'h0004, tap_capdr = 16'h0008,
		tap_shdr = 16'h0010, tap_ex1dr = 16'h0020, tap_pdr = 16'h0040, tap_ex2dr = 16'h0080,
		tap_upddr = 16'h0100, tap_selir = 16'h0200, tap_capir = 16'h0400, tap_shir = 16'h0800,
		tap_ex1ir = 16'h1000, tap_pir = 16'h2000, tap_ex2ir = 16'h4000, tap_updir = 16'h8000
	} jtbp_tap_e;

	typedef enum logic [1:0] {
		bpm_four_prog = 2'h0,
		bpm_three_one = 2'h1,
		bpm_two_two = 2'h2,
		bpm_two_range = 2'h3
	} jtbp_bpm_e;

	typedef struct packed {
		logic [2:0] tck_s;
		logic [1:0] tms_s;
		logic [1:0] tdi_s;
		jtbp_tap_e tap;
		logic [3:0] ir_sh;
		logic [3:0] ir;
		logic [67:0] dr;
		logic [15:0] instr;
		logic instr_stb;
		jtbp_bpm_e bp_mode;
		logic flow_en;
		logic step_en;
		logic [3:0][15:0] bp_addr;
		logic tdo;
		logic tdo_oe;
		logic brk;
		logic [2:0] tms_ones;
	} jtbp_top_s;

	function automatic jtbp_tap_e jtbp_tap_next(input jtbp_tap_e s, input logic tms);
		jtbp_tap_e n;
		n = tap_tlr;
		case (s)
			tap_tlr: n = tms ? tap_tlr : tap_rti;
			tap_rti: n = tms ? tap_seldr : tap_rti;
			tap_seldr: n = tms ? tap_selir : tap_capdr;
			tap_capdr: n = tms ? tap_ex1dr : tap_shdr;
			tap_shdr: n = tms ? tap_ex1dr : tap_shdr;
			tap_ex1dr: n = tms ? tap_upddr : tap_pdr;
			tap_pdr: n = tms ? tap_ex2dr : tap_pdr;
			tap_ex2dr: n = tms ? tap_upddr : tap_shdr;
			tap_upddr: n = tms ? tap_seldr : tap_rti;
			tap_selir: n = tms ? tap_tlr : tap_capir;
			tap_capir: n = tms ? tap_ex1ir : tap_shir;
			tap_shir: n = tms ? tap_ex1ir : tap_shir;
			tap_ex1ir: n = tms ? tap_updir : tap_pir;
			tap_pir: n = tms ? tap_ex2ir : tap_pir;
			tap_ex2ir: n = tms ? tap_updir : tap_shir;
			tap_updir: n = tms ? tap_seldr : tap_rti;
			default: n = tap_tlr;
		endcase
		return n;
	endfunction

endpackage

// File: verilog/jtbp_bp_if.sv
// Purpose: carries break point configuration and processor events
// Assumes: one clock, clk_sys
// Notes: ctl side is the port logic, bpu side the comparators
`timescale 1ns/1ns
interface jtbp_bp_if;
	import jtbp_pkg::*;
	jtbp_bpm_e mode;
	logic flow_en;
	logic step_en;
	logic [3:0][15:0] addr;
	logic [15:0] pc;
	logic pc_vld;
	logic [15:0] daddr;
	logic d_vld;
	logic flow;
	logic hit;
	modport ctl (output mode, flow_en, step_en, addr, pc, pc_vld, daddr, d_vld, flow, input hit);
	modport bpu (input mode, flow_en, step_en, addr, pc, pc_vld, daddr, d_vld, flow, output hit);
endinterface // jtbp_bp_if

// File: verilog/jtbp_fifo.sv
// Purpose: processor to debugger byte buffer
// Assumes: DEPTH a power of two
// Notes: read data registered; valid drops one cycle after each pop
`timescale 1ns/1ns
module jtbp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
		logic in_rdy;
		logic out_vld;
		logic [WIDTH-1:0] dout;
	} jtbp_fifo_s;

	jtbp_fifo_s st, nx;
	logic push, pop;

	always_comb begin
		nx = st;
		push = in_valid & st.in_rdy;
		pop = out_ready & st.out_vld;
		if (push) begin
			nx.mem[st.wp] = in_data;
			nx.wp = st.wp + 1'b1;
		end
		if (pop) begin
			nx.rp = st.rp + 1'b1;
		end
		if (push & ~pop) begin
			nx.cnt = st.cnt + 1'b1;
		end else if (pop & ~push) begin
			nx.cnt = st.cnt - 1'b1;
		end
		nx.in_rdy = nx.cnt != CW'(DEPTH);
		// data is sampled one cycle behind the pointer, so a pop must hide the stale word
		nx.out_vld = (st.cnt != '0) & ~pop;
		nx.dout = st.mem[st.rp];
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign in_ready = st.in_rdy;
	assign out_valid = st.out_vld;
	assign out_data = st.dout;

	fifo_full_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st.cnt == CW'(DEPTH) |-> !in_ready) else $error("fifo accepts data while full");
endmodule // jtbp_fifo

// File: verilog/jtbp_bpu.sv
// Purpose: break point comparators
// Assumes: pc_vld pulses once per executed instruction
// Notes: hit is registered, one cycle after the event
`timescale 1ns/1ns
module jtbp_bpu import jtbp_pkg::*; (
	input wire logic clk_sys,
	input wire logic sys_rst,
	jtbp_bp_if.bpu bp
);
	typedef struct packed {
		logic hit;
	} jtbp_bpu_s;

	jtbp_bpu_s st, nx;
	logic [3:0] pm;
	logic prog_hit, data_hit, rng_hit;

	always_comb begin
		nx = st;
		for (int i = 0; i < 4; i++) begin
			pm[i] = bp.pc == bp.addr[i];
		end
		rng_hit = (bp.pc & bp.addr[3]) == (bp.addr[2] & bp.addr[3]);
		prog_hit = 1'b0;
		data_hit = 1'b0;
		case (bp.mode)
			bpm_four_prog: prog_hit = |pm;
			bpm_three_one: begin
				prog_hit = |pm[2:0];
				data_hit = bp.daddr == bp.addr[3];
			end
			bpm_two_two: begin
				prog_hit = |pm[1:0];
				data_hit = (bp.daddr == bp.addr[2]) | (bp.daddr == bp.addr[3]);
			end
			bpm_two_range: prog_hit = (|pm[1:0]) | rng_hit;
			default: prog_hit = 1'b0;
		endcase
		nx.hit = (bp.pc_vld & (prog_hit | bp.step_en | (bp.flow_en & bp.flow))) | (bp.d_vld & data_hit);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign bp.hit = st.hit;

	step_break_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		bp.pc_vld && bp.step_en |=> bp.hit) else $error("single step gave no break");
	range_break_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		bp.pc_vld && bp.mode == bpm_two_range && rng_hit |=> bp.hit) else $error("range break missed");
	prog_four_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		bp.pc_vld && bp.mode == bpm_four_prog && bp.pc == bp.addr[3] |=> bp.hit) else $error("fourth break missed");
endmodule // jtbp_bpu

// File: dv/jtbp_tester.sv
// Purpose: debugger model driving tck, tms, tdi and sampling tdo
// Assumes: tck period 8 clk_sys (400 ns), high 4 and low 4
// Notes: tck stands low between frames; tms/tdi change one clk before tck rises
`timescale 1ns/1ns
module jtbp_tester (
	input wire logic clk_sys,
	input wire logic tdo_w,
	output logic tck,
	output logic tms,
	output logic tdi
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// tdo is read mid high phase: synchroniser latency makes the rise moment unsafe
	task automatic step(input logic m, input logic d, output logic q);
		@(posedge clk_sys);
		tms <= m;
		tdi <= d;
		@(posedge clk_sys);
		tck <= 1'b1;
		repeat (2) @(posedge clk_sys);
		q = tdo_w;
		repeat (2) @(posedge clk_sys);
		tck <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic shift(input int n, input logic [67:0] din, output logic [67:0] dout);
		logic q;
		dout = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
	endtask

	task automatic ir_scan(input logic [3:0] op, input bit idle, output logic [3:0] cap);
		logic q;
		logic [67:0] o;
		step(1'b1, 1'b1, q);
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		shift(4, {64'h0, op}, o);
		cap = o[3:0];
		step(1'b1, 1'b1, q);
		step(!idle, 1'b1, q);
	endtask

	task automatic dr_scan(input int n, input logic [67:0] din, input bit from_sel, output logic [67:0] dout);
		logic q;
		if (!from_sel) begin
			step(1'b1, 1'b1, q);
		end
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		shift(n, din, dout);
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
endmodule // jtbp_tester

// File: dv/jtag_tap_debug_breakpoints_tb.sv
// Purpose: self-checking bench of jtbp_top against the tester model
// Assumes: FIFO_DEPTH 4 to keep fill and drain short
// Notes: tdo wire pulled up when not driven
`timescale 1ns/1ns
module jtag_tap_debug_breakpoints_tb;
	import jtbp_pkg::*;
	logic clk_sys, sys_rst, tck, tms, tdi, tdo, tdo_oe, tdo_w, q0;
	logic [3:0] ir_out;
	logic [15:0] cpu_pc, cpu_daddr, cpu_instr;
	logic cpu_pc_vld, cpu_dacc, cpu_flow_chg, cpu_instr_stb, dbg_break, cpu_ocd_wr, cpu_ocd_ready;
	logic [7:0] cpu_ocd_data;
	logic [67:0] prev_cfg;
	int n_fail, cmp_count, n_stb, n_brk;

	assign tdo_w = tdo_oe ? tdo : 1'b1;

	jtbp_top #(.FIFO_DEPTH(4)) jtbp_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ir_out(ir_out), .cpu_pc(cpu_pc), .cpu_pc_vld(cpu_pc_vld),
		.cpu_daddr(cpu_daddr), .cpu_dacc(cpu_dacc), .cpu_flow_chg(cpu_flow_chg), .cpu_instr(cpu_instr),
		.cpu_instr_stb(cpu_instr_stb), .dbg_break(dbg_break), .cpu_ocd_data(cpu_ocd_data),
		.cpu_ocd_wr(cpu_ocd_wr), .cpu_ocd_ready(cpu_ocd_ready));
	jtbp_tester jtbp_tester_i (.clk_sys(clk_sys), .tdo_w(tdo_w), .tck(tck), .tms(tms), .tdi(tdi));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (cpu_instr_stb === 1'b1) n_stb++;
		if (dbg_break === 1'b1) n_brk++;
	end

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [67:0] got, input logic [67:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	function automatic logic [67:0] mk(input logic [1:0] m, input logic f, input logic s, input logic [15:0] a3);
		return {a3, 16'h0300, 16'h0200, 16'h0100, s, f, m};
	endfunction

	task automatic t_reset;
		chk(ir_out, 4'hF, "ir after reset");
		chk(tdo_oe, 1'b0, "oe after reset");
		chk(cpu_instr, 16'h0000, "instr after reset");
	endtask

	task automatic t_ir;
		logic [3:0] cap;
		logic [3:0] ops [5] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hF};
		foreach (ops[i]) begin
			jtbp_tester_i.ir_scan(ops[i], 1'b1, cap);
			chk(cap, 4'h1, "ir capture");
			chk(ir_out, ops[i], "ir update");
		end
	endtask

	task automatic t_scan;
		logic [3:0] cap;
		logic [67:0] got;
		@(posedge clk_sys);
		cpu_pc <= 16'hA5C3;
		jtbp_tester_i.ir_scan(4'h8, 1'b0, cap);
		jtbp_tester_i.dr_scan(16, 68'h9E61, 1'b1, got);
		chk(got, 16'hA5C3, "scan capture");
		chk(cpu_instr, 16'h9E61, "scan update");
	endtask

	task automatic t_exec;
		logic [3:0] cap;
		logic q;
		int n0;
		jtbp_tester_i.ir_scan(4'h9, 1'b1, cap);
		n0 = n_stb;
		repeat (3) jtbp_tester_i.step(1'b0, 1'b0, q);
		repeat (4) @(posedge clk_sys);
		chk(n_stb - n0, 3, "idle strobes");
	endtask

	task automatic bp_case(input logic [67:0] cfg, input logic [15:0] a, input logic dat, input logic fl, input int exp);
		logic [67:0] got;
		int n0;
		jtbp_tester_i.dr_scan(68, cfg, 1'b0, got);
		chk(got, prev_cfg, "bp readback");
		prev_cfg = cfg;
		n0 = n_brk;
		@(posedge clk_sys);
		cpu_pc <= a;
		cpu_daddr <= a;
		cpu_pc_vld <= !dat;
		cpu_dacc <= dat;
		cpu_flow_chg <= fl;
		@(posedge clk_sys);
		cpu_pc_vld <= 1'b0;
		cpu_dacc <= 1'b0;
		cpu_flow_chg <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk(n_brk - n0, exp, "break count");
	endtask

	task automatic t_bp;
		logic [3:0] cap;
		prev_cfg = '0;
		jtbp_tester_i.ir_scan(4'hA, 1'b1, cap);
		bp_case(mk(2'h0, 1'b0, 1'b0, 16'h0400), 16'h0300, 1'b0, 1'b0, 1);
		bp_case(mk(2'h1, 1'b0, 1'b0, 16'h0400), 16'h0400, 1'b1, 1'b0, 1);
		bp_case(mk(2'h2, 1'b0, 1'b0, 16'h0400), 16'h0300, 1'b1, 1'b0, 1);
		bp_case(mk(2'h3, 1'b0, 1'b0, 16'hFF00), 16'h0345, 1'b0, 1'b0, 1);
		bp_case(mk(2'h0, 1'b0, 1'b0, 16'h0400), 16'h0777, 1'b0, 1'b1, 0);
		bp_case(mk(2'h0, 1'b1, 1'b0, 16'h0400), 16'h0777, 1'b0, 1'b1, 1);
		bp_case(mk(2'h0, 1'b0, 1'b1, 16'h0400), 16'h0777, 1'b0, 1'b0, 1);
	endtask

	task automatic ocd_wr(input logic [7:0] b);
		@(posedge clk_sys);
		cpu_ocd_data <= b;
		cpu_ocd_wr <= 1'b1;
		for (int k = 0; k <= 20; k++) begin
			@(posedge clk_sys);
			if (cpu_ocd_ready === 1'b1) break;
			if (k == 20) begin
				n_fail++;
				$display("[FAIL] %0t byte channel never ready", $time);
				report_and_stop();
			end
		end
		cpu_ocd_wr <= 1'b0;
	endtask

	task automatic t_comm;
		logic [3:0] cap;
		logic [67:0] got;
		for (int i = 0; i < 4; i++) ocd_wr(8'h51 + 8'(i * 34));
		repeat (3) @(posedge clk_sys);
		chk(cpu_ocd_ready, 1'b0, "full refuses");
		jtbp_tester_i.ir_scan(4'hB, 1'b1, cap);
		for (int i = 0; i < 5; i++) begin
			jtbp_tester_i.dr_scan(9, 68'h0, 1'b0, got);
			chk(got, i < 4 ? {1'b1, 8'h51 + 8'(i * 34)} : 9'h000, "byte read");
		end
		chk(cpu_ocd_ready, 1'b1, "drained ready");
	endtask

	task automatic t_tlr;
		logic [3:0] cap;
		logic q;
		jtbp_tester_i.ir_scan(4'h8, 1'b1, cap);
		jtbp_tester_i.step(1'b1, 1'b0, q);
		repeat (3) jtbp_tester_i.step(1'b0, 1'b1, q);
		repeat (5) jtbp_tester_i.step(1'b1, 1'b0, q);
		chk(ir_out, 4'hF, "five ones reset");
		chk(tdo_oe, 1'b0, "oe off in reset");
		jtbp_tester_i.step(1'b0, 1'b0, q);
	endtask

	initial begin
		n_fail = 0;
		cmp_count = 0;
		n_stb = 0;
		n_brk = 0;
		sys_rst = 1'b1;
		cpu_pc = 16'h0000;
		cpu_pc_vld = 1'b0;
		cpu_daddr = 16'h0000;
		cpu_dacc = 1'b0;
		cpu_flow_chg = 1'b0;
		cpu_ocd_data = 8'h00;
		cpu_ocd_wr = 1'b0;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		t_reset();
		chk(cpu_ocd_ready, 1'b1, "ready after reset");
		jtbp_tester_i.step(1'b0, 1'b0, q0);
		t_ir();
		t_scan();
		t_exec();
		t_bp();
		t_comm();
		t_tlr();
		report_and_stop();
	end
endmodule // jtag_tap_debug_breakpoints_tb
